// *** hw/dsp_pkg.sv ***
// Constants and carrier types for the separate-I/O double-data-rate burst SRAM port
package dsp_pkg;
  localparam int DATA_W = 36;
  localparam int LANE_N = 4;
  localparam int ADDR_W = 4;
  localparam int DEPTH  = 2 ** (ADDR_W + 1);
  localparam int SLOT_N = 4;
  // Half-cycle slots after the command edge
  localparam int WR_H0     = 2;
  localparam int RD_H0_DLL = 3;
  localparam int RD_H0_OFF = 2;
  localparam logic [1:0] ORG_X8  = 2'h0;
  localparam logic [1:0] ORG_X9  = 2'h1;
  localparam logic [1:0] ORG_X18 = 2'h2;
  localparam logic [1:0] ORG_X36 = 2'h3;
  localparam logic [1:0] RST_ORG = 2'h3;
  localparam logic PHASE_K_RISE  = 1'h0;
  localparam logic [DATA_W-1:0] RST_WORD = 36'h0;

  typedef struct packed {
    logic              load_strobe_n;
    logic              read_not_write;
    logic [ADDR_W-1:0] addr;
  } dsp_cmd_type;

  typedef struct packed {
    logic              v;
    logic              rd;
    logic [ADDR_W-1:0] addr;
  } dsp_slot_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] wen;
  } dsp_half_type;
endpackage

// *** hw/dsp_sram_port.sv ***
// Burst SRAM port: command decode, burst sequencing, lane-masked writes and read launch
`timescale 1ns/1ps
`default_nettype none
module dsp_sram_port (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       clk_run,
  input  wire logic                       dll_disable_n,
  input  wire logic [1:0]                 org_strap,
  input  wire dsp_pkg::dsp_cmd_type       cmd,
  input  wire logic [dsp_pkg::DATA_W-1:0] wr_data,
  input  wire logic [3:0]                 byte_lane_select_n,
  input  wire logic [1:0]                 nibble_lane_select_n,
  output logic      [dsp_pkg::DATA_W-1:0] rd_data,
  output logic                            rd_data_oe
);
  logic                       phase_q;
  logic [1:0]                 org_q;
  logic                       org_done_q;
  dsp_pkg::dsp_slot_type      slot_q [1:dsp_pkg::SLOT_N];
  logic                       pend_v_q;
  logic [dsp_pkg::ADDR_W-1:0] pend_addr_q;
  dsp_pkg::dsp_half_type      pend0_q;
  dsp_pkg::dsp_half_type      pend1_q;
  logic [dsp_pkg::DATA_W-1:0] mem_q [dsp_pkg::DEPTH];
  logic [dsp_pkg::DATA_W-1:0] q_q;
  logic                       oe_q;
  logic                       word_q;

  // Command decode; commands are only taken on the K-rise phase
  wire cmd_fire = clk_run & (phase_q == dsp_pkg::PHASE_K_RISE) & ~cmd.load_strobe_n;
  wire rd_fire  = cmd_fire & cmd.read_not_write;
  wire wr_fire  = cmd_fire & ~cmd.read_not_write;
  wire dsp_pkg::dsp_slot_type new_slot = '{v: cmd_fire, rd: cmd.read_not_write, addr: cmd.addr};

  // Read launch slots move one half-cycle earlier with the DLL off
  wire dsp_pkg::dsp_slot_type rd_s0 = dll_disable_n ? slot_q[dsp_pkg::RD_H0_DLL]
                                                    : slot_q[dsp_pkg::RD_H0_OFF];
  wire dsp_pkg::dsp_slot_type rd_s1 = dll_disable_n ? slot_q[dsp_pkg::RD_H0_DLL + 1]
                                                    : slot_q[dsp_pkg::RD_H0_OFF + 1];
  wire launch0 = clk_run & rd_s0.v & rd_s0.rd;
  wire launch1 = clk_run & rd_s1.v & rd_s1.rd;
  wire launch  = launch0 | launch1;
  // Write halves are captured two and three edges after the command
  wire dsp_pkg::dsp_slot_type wr_s0 = slot_q[dsp_pkg::WR_H0];
  wire dsp_pkg::dsp_slot_type wr_s1 = slot_q[dsp_pkg::WR_H0 + 1];
  wire wr_cap0 = clk_run & wr_s0.v & ~wr_s0.rd;
  wire wr_cap1 = clk_run & wr_s1.v & ~wr_s1.rd;

  // Lane selects: the x8 part uses its two nibble selects as lanes 0 and 1
  wire [3:0] sel_n = (org_q == dsp_pkg::ORG_X8) ? {2'h3, nibble_lane_select_n} : byte_lane_select_n;
  wire       is_x8  = (org_q == dsp_pkg::ORG_X8);
  wire       is_x9  = (org_q == dsp_pkg::ORG_X9);
  wire       is_x18 = (org_q == dsp_pkg::ORG_X18);
  wire       is_x36 = (org_q == dsp_pkg::ORG_X36);
  logic [dsp_pkg::DATA_W-1:0] wen;
  logic [dsp_pkg::DATA_W-1:0] width_mask;

  // Per-bit write enable from the lane that owns the bit in each width
  for (genvar i = 0; i < dsp_pkg::DATA_W; i++) begin : g_lane
    localparam int L4 = (i < 8) ? i / 4 : 0;
    localparam int L9 = i / 9;
    localparam int L9S = (i < 18) ? i / 9 : 0;
    assign wen[i] = (is_x8 & (i < 8) & ~sel_n[L4])
                  | (is_x9 & (i < 9) & ~sel_n[0])
                  | (is_x18 & (i < 18) & ~sel_n[L9S])
                  | (is_x36 & ~sel_n[L9]);
    assign width_mask[i] = (is_x8 & (i < 8)) | (is_x9 & (i < 9)) | (is_x18 & (i < 18)) | is_x36;
  end

  // Read merge: a held write to the same address overrides the array per lane
  wire [dsp_pkg::ADDR_W-1:0]   rd_addr = launch1 ? rd_s1.addr : rd_s0.addr;
  wire [dsp_pkg::ADDR_W:0]     rd_idx  = {rd_addr, launch1};
  wire                         rd_hit  = pend_v_q & (pend_addr_q == rd_addr);
  wire dsp_pkg::dsp_half_type  rd_pend = launch1 ? pend1_q : pend0_q;
  wire [dsp_pkg::DATA_W-1:0]   rd_word = rd_hit ? ((mem_q[rd_idx] & ~rd_pend.wen) | (rd_pend.data & rd_pend.wen))
                                                : mem_q[rd_idx];
  wire                         commit  = wr_cap0 & pend_v_q;

  // Edge phase: even edges are K rises, odd edges K-bar rises; frozen while stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= dsp_pkg::PHASE_K_RISE;
    end else if (clk_run) begin
      phase_q <= ~phase_q;
    end
  end

  // Width strap caught once at the first edge after reset, whether or not the clock is running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      org_q      <= dsp_pkg::RST_ORG;
      org_done_q <= 1'h0;
    end else if (!org_done_q) begin
      org_q      <= org_strap;
      org_done_q <= 1'h1;
    end
  end

  // Half-cycle command pipeline shared by reads and writes
  for (genvar s = 1; s <= dsp_pkg::SLOT_N; s++) begin : g_slot
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        slot_q[s] <= '0;
      end else if (clk_run) begin
        slot_q[s] <= (s == 1) ? new_slot : slot_q[(s == 1) ? 1 : s - 1];
      end
    end
  end

  // Posted-write holder: both halves keep their own mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_v_q    <= 1'h0;
      pend_addr_q <= '0;
      pend0_q     <= '0;
      pend1_q     <= '0;
    end else begin
      if (wr_cap0) begin
        pend_v_q    <= 1'h1;
        pend_addr_q <= wr_s0.addr;
        pend0_q     <= '{data: wr_data, wen: wen};
        pend1_q     <= '0;
      end
      if (wr_cap1) begin
        pend1_q <= '{data: wr_data, wen: wen};
      end
    end
  end

  // Array: the held burst is written when the next write's first half arrives
  for (genvar e = 0; e < dsp_pkg::DEPTH; e++) begin : g_mem
    localparam logic [dsp_pkg::ADDR_W:0] IDX = (dsp_pkg::ADDR_W + 1)'(e);
    wire hit0 = commit & ({pend_addr_q, 1'h0} == IDX);
    wire hit1 = commit & ({pend_addr_q, 1'h1} == IDX);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_q[e] <= dsp_pkg::RST_WORD;
      end else if (hit0) begin
        mem_q[e] <= (mem_q[e] & ~pend0_q.wen) | (pend0_q.data & pend0_q.wen);
      end else if (hit1) begin
        mem_q[e] <= (mem_q[e] & ~pend1_q.wen) | (pend1_q.data & pend1_q.wen);
      end
    end
  end

  // Output register: drives only on launch edges, holds everything while stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q    <= dsp_pkg::RST_WORD;
      oe_q   <= 1'h0;
      word_q <= 1'h0;
    end else if (clk_run) begin
      if (launch) begin
        q_q <= rd_word;
      end
      oe_q   <= launch;
      word_q <= launch1;
    end
  end

  assign rd_data    = q_q;
  assign rd_data_oe = oe_q;

  // All checks share the one clock and go quiet while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rd_lat_dll;
    rd_fire && dll_disable_n ##1 clk_run [*3] ##1 1'h1 |-> rd_data_oe && !word_q;
  endproperty
  a_rd_lat_dll: assert property (p_rd_lat_dll) else $error("read word 0 late with DLL on");

  property p_rd_lat_off;
    rd_fire && !dll_disable_n ##1 clk_run [*2] |=> rd_data_oe && !word_q;
  endproperty
  a_rd_lat_off: assert property (p_rd_lat_off) else $error("read word 0 late with DLL off");

  property p_burst_seq;
    rd_data_oe && !word_q && clk_run |=> rd_data_oe && word_q;
  endproperty
  a_burst_seq: assert property (p_burst_seq) else $error("second burst word missing");

  property p_stop_hold;
    !clk_run |=> $stable(rd_data) && $stable(rd_data_oe);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("outputs moved with clock stopped");

  property p_nop_hiz;
    clk_run && !slot_q[2].v && !slot_q[3].v && !slot_q[4].v |=> !rd_data_oe;
  endproperty
  a_nop_hiz: assert property (p_nop_hiz) else $error("output driven with no read pending");

  property p_none_sel;
    (sel_n == 4'hF) |-> (wen == '0);
  endproperty
  a_none_sel: assert property (p_none_sel) else $error("write enable with all lanes off");

  property p_all_sel;
    (sel_n == 4'h0) |-> (wen == width_mask);
  endproperty
  a_all_sel: assert property (p_all_sel) else $error("partial write with all lanes on");

  property p_commit;
    commit ##1 1'h1 |-> mem_q[{$past(pend_addr_q), 1'h0}] ==
      (($past(mem_q[{pend_addr_q, 1'h0}]) & ~$past(pend0_q.wen)) | ($past(pend0_q.data) & $past(pend0_q.wen)));
  endproperty
  a_commit: assert property (p_commit) else $error("held write not committed");

  // A write command's first half and address reach the holder two running edges later
  property p_wr_capture;
    wr_fire ##1 clk_run [*2] |=>
      pend_v_q && (pend_addr_q == $past(cmd.addr, 3)) && (pend0_q.data == $past(wr_data));
  endproperty
  a_wr_capture: assert property (p_wr_capture) else $error("write half 0 not captured");

  // First data half is always taken on a K rise
  property p_wr_k_edge;
    wr_cap0 |-> (phase_q == dsp_pkg::PHASE_K_RISE);
  endproperty
  a_wr_k_edge: assert property (p_wr_k_edge) else $error("write half 0 off the K rise");

  // Second half keeps its own data and mask
  property p_wr_half1;
    wr_cap1 |=> (pend1_q.data == $past(wr_data)) && (pend1_q.wen == $past(wen));
  endproperty
  a_wr_half1: assert property (p_wr_half1) else $error("write half 1 not captured");

  // Second data half is always taken on a K-bar rise
  property p_wr_kbar_edge;
    wr_cap1 |-> (phase_q != dsp_pkg::PHASE_K_RISE);
  endproperty
  a_wr_kbar_edge: assert property (p_wr_kbar_edge) else $error("write half 1 off the K-bar rise");

  // Phase alternates on every running edge, so commands land on alternate edges
  property p_phase_run;
    clk_run |=> (phase_q != $past(phase_q));
  endproperty
  a_phase_run: assert property (p_phase_run) else $error("edge phase did not alternate");

  // Phase and pipeline entry freeze while the clock is stopped
  property p_phase_hold;
    !clk_run |=> $stable(phase_q) && $stable(slot_q[1]);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("pipeline moved with clock stopped");

  // A launch edge registers the selected read word and drives it
  property p_rd_launch;
    launch |=> rd_data_oe && (rd_data == $past(rd_word));
  endproperty
  a_rd_launch: assert property (p_rd_launch) else $error("read word not launched");

  // Without a launch the output goes off and the last word is kept
  property p_rd_idle;
    clk_run && !launch |=> !rd_data_oe && $stable(rd_data);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("output active without a launch");

  // Selected lanes of a held write override the array on a read
  property p_rd_merge;
    launch && rd_hit |=> ((rd_data ^ $past(rd_pend.data)) & $past(rd_pend.wen)) == '0;
  endproperty
  a_rd_merge: assert property (p_rd_merge) else $error("held write not forwarded");

  // First word comes from the even location of the latched address
  property p_rd_word0;
    launch0 && !launch1 && !rd_hit |=> rd_data == $past(mem_q[{rd_s0.addr, 1'h0}]);
  endproperty
  a_rd_word0: assert property (p_rd_word0) else $error("first read word from wrong location");

  // Second word comes from the next location
  property p_rd_word1;
    launch1 && !rd_hit |=> rd_data == $past(mem_q[{rd_s1.addr, 1'h1}]);
  endproperty
  a_rd_word1: assert property (p_rd_word1) else $error("second read word from wrong location");

  // Odd word of the held burst: selected lanes written, the rest kept
  property p_commit_hi;
    commit |=>
      (((mem_q[{$past(pend_addr_q), 1'h1}] ^ $past(mem_q[{pend_addr_q, 1'h1}])) & ~$past(pend1_q.wen)) == '0) &&
      (((mem_q[{$past(pend_addr_q), 1'h1}] ^ $past(pend1_q.data)) & $past(pend1_q.wen)) == '0);
  endproperty
  a_commit_hi: assert property (p_commit_hi) else $error("held second word not committed");

  // Holder only changes on a capture edge, so intervening reads cannot disturb it
  property p_pend_keep;
    !wr_cap0 && !wr_cap1 |=>
      $stable(pend0_q) && $stable(pend1_q) && $stable(pend_addr_q) && $stable(pend_v_q);
  endproperty
  a_pend_keep: assert property (p_pend_keep) else $error("held write changed without capture");

  // x8: each nibble select guards its own four bits
  property p_x8_lanes;
    is_x8 |-> wen == {28'h0, {4{~sel_n[1]}}, {4{~sel_n[0]}}};
  endproperty
  a_x8_lanes: assert property (p_x8_lanes) else $error("x8 nibble enables wrong");

  // x9: the single select guards all nine bits
  property p_x9_lane;
    is_x9 |-> wen == {27'h0, {9{~sel_n[0]}}};
  endproperty
  a_x9_lane: assert property (p_x9_lane) else $error("x9 byte enable wrong");

  // x18: two byte selects guard bits 8:0 and 17:9
  property p_x18_lanes;
    is_x18 |-> wen == {18'h0, {9{~sel_n[1]}}, {9{~sel_n[0]}}};
  endproperty
  a_x18_lanes: assert property (p_x18_lanes) else $error("x18 byte enables wrong");

  // x36: each of the four selects guards its own nine bits
  property p_x36_lanes;
    is_x36 |-> wen == {{9{~sel_n[3]}}, {9{~sel_n[2]}}, {9{~sel_n[1]}}, {9{~sel_n[0]}}};
  endproperty
  a_x36_lanes: assert property (p_x36_lanes) else $error("x36 byte enables wrong");

  // x36: select 0 alone leaves bits 35:9 untouched
  property p_x36_low;
    is_x36 && (sel_n == 4'hE) |-> wen == {27'h0, 9'h1FF};
  endproperty
  a_x36_low: assert property (p_x36_low) else $error("x36 low byte enable wrong");
endmodule
`default_nettype wire

// *** verif/dsp_ctrl_model.sv ***
// Memory controller model: issues commands and drives the write data halves
`timescale 1ns/1ps
`default_nettype none
module dsp_ctrl_model (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_run,
  output var dsp_pkg::dsp_cmd_type   cmd,
  output logic [dsp_pkg::DATA_W-1:0] wr_data,
  output logic [3:0]                 byte_lane_select_n,
  output logic [1:0]                 nibble_lane_select_n
);
  // Output clocks are not modelled: the single clock strap is fixed and never changed in a run
  int cnt;
  int wseq;
  // Running-edge index; even indices are positive input clock rises
  always @(posedge clk or negedge rst_n)
    if (!rst_n) cnt <= 0;
    else if (clk_run) cnt <= cnt + 1;
  initial begin
    cmd = '{1'h1, 1'h0, 4'h0};
    wr_data = 36'h0;
    byte_lane_select_n = 4'hF;
    nibble_lane_select_n = 2'h3;
    wseq = 0;
  end
  task automatic put(input logic [35:0] d, input logic [3:0] s);
    wr_data <= d;
    byte_lane_select_n <= s;
    nibble_lane_select_n <= s[1:0];
  endtask
  // Command driven on an odd edge so it is taken on the next even one
  task automatic issue(input logic rd, input logic [3:0] a, input logic [35:0] d0, d1,
                       input logic [3:0] s0, s1, output int e);
    do @(posedge clk); while (!(clk_run && cnt[0]));
    cmd <= '{1'h0, rd, a};
    @(posedge clk);
    e = cnt;
    cmd <= '{1'h1, ~rd, ~a};
    // Only writes own the data lines, so a read must not cancel their release
    if (!rd) wseq++;
    if (!rd) fork
      begin
        int my = wseq;
        @(posedge clk);
        put(d0, s0);
        @(posedge clk);
        put(d1, s1);
        @(posedge clk);
        // Released lines show the inverse, unless a newer write owns them
        if (my == wseq) put(~d1, ~s1);
      end
    join_none
  endtask
endmodule
`default_nettype wire

// *** verif/dsp_sram_port_test.sv ***
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ps
`default_nettype none
module dsp_sram_port_test;
  logic                 clk = 1'h0;
  logic                 rst_n = 1'h0;
  logic                 clk_run = 1'h1;
  logic                 dll_disable_n = 1'h1;
  logic                 ran = 1'h0;
  logic [1:0]           org_strap = dsp_pkg::RST_ORG;
  logic                 rd_data_oe;
  logic [35:0]          rd_data;
  logic [35:0]          wr_data;
  logic [3:0]           bls;
  logic [1:0]           nls;
  logic [35:0]          mem [32];
  logic [35:0]          exp_q [$];
  int                   due_q [$];
  int                   n_fail = 0;
  int                   comparisons = 0;
  dsp_pkg::dsp_cmd_type cmd;
  dsp_sram_port i_dut (.clk(clk), .rst_n(rst_n), .clk_run(clk_run), .dll_disable_n(dll_disable_n),
    .org_strap(org_strap), .cmd(cmd), .wr_data(wr_data), .byte_lane_select_n(bls),
    .nibble_lane_select_n(nls), .rd_data(rd_data), .rd_data_oe(rd_data_oe));
  dsp_ctrl_model i_ctrl (.clk(clk), .rst_n(rst_n), .clk_run(clk_run), .cmd(cmd), .wr_data(wr_data),
    .byte_lane_select_n(bls), .nibble_lane_select_n(nls));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [35:0] got, input logic [35:0] want);
    comparisons++;
    if (got !== want) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // Bits written for a given select pattern in the strapped width
  function automatic logic [35:0] lanes(input logic [3:0] s);
    lanes = 36'h0;
    if (org_strap == dsp_pkg::ORG_X8) lanes = {28'h0, {4{~s[1]}}, {4{~s[0]}}};
    else for (int i = 0; i < 4; i++)
      if (!s[i] && i < (org_strap == dsp_pkg::ORG_X9 ? 1 : org_strap == dsp_pkg::ORG_X18 ? 2 : 4))
        lanes[9*i +: 9] = 9'h1FF;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [35:0] d0, d1, input logic [3:0] s0, s1);
    int e;
    i_ctrl.issue(1'h0, a, d0, d1, s0, s1, e);
    mem[{a, 1'h0}] = (mem[{a, 1'h0}] & ~lanes(s0)) | (d0 & lanes(s0));
    mem[{a, 1'h1}] = (mem[{a, 1'h1}] & ~lanes(s1)) | (d1 & lanes(s1));
  endtask
  // Read words are due one edge (a half-cycle) earlier with the DLL off
  task automatic rd(input logic [3:0] a);
    int e;
    i_ctrl.issue(1'h1, a, 36'h0, 36'h0, 4'hF, 4'hF, e);
    due_q.push_back(e + (dll_disable_n ? 4 : 3));
    due_q.push_back(e + (dll_disable_n ? 5 : 4));
    exp_q.push_back(mem[{a, 1'h0}]);
    exp_q.push_back(mem[{a, 1'h1}]);
  endtask
  always @(posedge clk) ran <= clk_run && rst_n;
  // Stopped edges are skipped, so frozen words are not counted twice
  always @(negedge clk)
    if (rst_n && ran) begin
      if (due_q.size() > 0 && due_q[0] == i_ctrl.cnt) begin
        chk(rd_data_oe, 1);
        chk((rd_data ^ exp_q[0]) & lanes(4'h0), 0);
        void'(due_q.pop_front());
        void'(exp_q.pop_front());
      end
      else chk(rd_data_oe, 0);
    end
  task automatic do_reset(input logic [1:0] o);
    @(posedge clk);
    rst_n <= 1'h0;
    org_strap <= o;
    dll_disable_n <= ~o[0];
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    foreach (mem[i]) mem[i] = 36'h0;
    chk(rd_data_oe, 0);
  endtask
  task automatic t_lanes(input logic [1:0] o);
    logic [3:0] sel [6] = '{4'hF, 4'h0, 4'hE, 4'hD, 4'hB, 4'h7};
    do_reset(o);
    for (int k = 0; k < 6; k++) wr(4'(k), 36'hFFFFFFFFF, 36'hFFFFFFFFF, 4'h0, 4'h0);
    for (int k = 0; k < 6; k++) wr(4'(k), 36'hC3A596E17 ^ 36'(k), 36'h3C5A691E8, sel[k], sel[5-k]);
    for (int k = 0; k < 6; k++) rd(4'(k));
    repeat (8) @(posedge clk);
    chk(32'(due_q.size()), 0);
    $display("Lane test done for width code %0d", o);
  endtask
  task automatic t_alt();
    for (int k = 0; k < 4; k++) begin
      wr(4'(8 + k), 36'h123456789 + 36'(k), 36'hFEDCBA987, 4'h0, 4'h5);
      rd(4'(8 + k));
    end
    repeat (8) @(posedge clk);
    $display("Alternating test done");
  endtask
  task automatic t_stop();
    logic [35:0] held;
    rd(4'h9);
    repeat (3) @(posedge clk);
    clk_run <= 1'h0;
    @(negedge clk);
    held = rd_data;
    repeat (6) begin
      @(negedge clk);
      chk(rd_data, held);
      chk(rd_data_oe, 1);
    end
    @(posedge clk);
    clk_run <= 1'h1;
    rd(4'hA);
    repeat (8) @(posedge clk);
    $display("Clock stop test done");
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    for (int o = 0; o < 4; o++) t_lanes(2'(o));
    t_alt();
    t_stop();
    report_and_stop();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
